// ### rtl/ckpm_ctrl.sv
`timescale 1ns/1ns
// Contract
// - Idle stops the core, keeps power and clocks, wakes at once on an event.
// - Wait instruction with deep select 0 enters idle.
// - Wait instruction with deep select 1 enters halt, sleep or shutdown.
// - Peripheral clocks stay individually gateable in idle.
// - Halt stops clocks; wake restarts clocks before releasing the core.
// - Keep bit 3 chooses whether fast crystal and PLL run in halt.
// - Idle and halt wake on GPIO, RTC, battery or USB.
// - Sleep turns off main regulator; low-power regulator feeds PMU, core, peripherals. Code keeps main_reg on in sleep while PLAN_LDO is set.
// - Sleep keeps slow oscillators and RAM or USB/RF supply by software choice.
// - Sleep wake: main regulator, then clock, then core resumes.
// - Sleep and shutdown wake only on GPIO, RTC, battery.
// - Shutdown powers off core, peripherals, USB/RF; RAM and slow osc optional.
// - Shutdown wake issues global reset and sets the reset cause flag.
// - Source 00/10 fast crystal divided, 01 PLL divided, 11 raw slow.
// - Divider divides by value, 0 means 32, 1 stops clock, reset 5.
// - PLL is 15 times the crystal; USB data clocked from PLL.
// - PLL power bit 4 powers PLL, resets to 1.
// - Fast crystal power bit 2 switches it independently.
// - Slow select 1 picks crystal, 0 picks RC oscillator.
// - Plan arm applies on next sleep or shutdown, then clears itself.
// - Switcher bias and enable act at once when written.
module ckpm_ctrl
   import ckpm_pkg::*;
#(
   parameter int NPERIPH = 8
)(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              wait_exec,
   input  wire logic              deep_sleep_select,
   input  wire logic              wake_gpio,
   input  wire logic              wake_rtc,
   input  wire logic              wake_bat,
   input  wire logic              wake_usb,
   input  wire logic              fast_tick,
   input  wire logic              pll_tick,
   input  wire logic              slow_xtal_tick,
   input  wire logic              slow_rc_tick,
   output logic                   core_run,
   output logic                   sys_clk_en,
   output logic      [NPERIPH-1:0] periph_clk_en,
   output logic                   usb_clk_en,
   output ckpm_pwr_s              pwr,
   output logic                   global_wake_reset,
   output logic                   reset_cause_flag
);

   ////////////////////////////////////////////////////////////////////////
   logic [15:0]        sys_cfg;
   logic [7:0]         fast_pwr;
   logic [15:0]        rc_tune;
   logic [7:0]         xt_tune;
   logic [7:0]         slow_cfg;
   logic [7:0]         pll_cfg;
   logic [7:0]         fxt_tune;
   logic [7:0]         cal_ctrl;
   logic [15:0]        plan;
   logic [7:0]         wake_ctrl;
   logic [NPERIPH-1:0] periph_gate;
   logic               unlock_half;
   logic [7:0]         unlock_cnt;
   ckpm_state_e        state;
   ckpm_state_e        next_state;
   logic [7:0]         wait_cnt;
   logic [3:0]         wk_s1;
   logic [3:0]         wk_s2;
   logic [3:0]         wk_s3;
   logic [3:0]         wk_lvl;
   logic [1:0]         sh_src;
   logic [4:0]         sh_div;
   logic [5:0]         div_cnt;

   // Register decode
   wire unlocked  = (unlock_cnt != 8'h00);
   wire wr_sig    = wr_en && (addr == OFS_UNLOCK_SIG);
   wire wr_prot   = wr_en && unlocked && !wr_sig;
   wire wr_sys    = wr_prot && (addr == OFS_SYS_CLK_CFG);
   wire wr_fast   = wr_prot && (addr == OFS_FAST_PWR);
   wire wr_rc     = wr_prot && (addr == OFS_SLOW_RC_TUNE);
   wire wr_xt     = wr_prot && (addr == OFS_SLOW_XT_TUNE);
   wire wr_slow   = wr_prot && (addr == OFS_SLOW_OSC_CFG);
   wire wr_pll    = wr_prot && (addr == OFS_PLL_CFG);
   wire wr_fxt    = wr_prot && (addr == OFS_FAST_XT_TUNE);
   wire wr_cal    = wr_prot && (addr == OFS_CAL_CTRL);
   wire wr_plan   = wr_prot && (addr == OFS_POWER_PLAN);
   wire wr_wake   = wr_prot && (addr == OFS_WAKE_CTRL);
   wire wr_gate   = wr_prot && (addr == OFS_PERIPH_GATE);
   // Status write is open: clearing the cause flag needs no unlock
   wire wr_stat   = wr_en && (addr == OFS_PMU_STATUS);

   // Wake decode: USB only counts in idle and halt, never in sleep or shutdown
   wire wake_shallow = (wk_lvl[0] & wake_ctrl[WK_GPIO]) | (wk_lvl[1] & wake_ctrl[WK_RTC])
                     | (wk_lvl[2] & wake_ctrl[WK_BAT]) | (wk_lvl[3] & wake_ctrl[WK_USB]);
   wire wake_deep    = (wk_lvl[0] & wake_ctrl[WK_GPIO]) | (wk_lvl[1] & wake_ctrl[WK_RTC])
                     | (wk_lvl[2] & wake_ctrl[WK_BAT]);

   // Deep entry picks halt, sleep or shutdown from the armed plan
   wire plan_armed = plan[PLAN_ARM];
   wire plan_low   = plan_armed && !plan[PLAN_SYS];
   wire deep_tgt_sleep = plan_low && plan[PLAN_CORE];
   wire deep_tgt_shut  = plan_low && !plan[PLAN_CORE];
   wire enter_idle = (state == ST_RUN) && wait_exec && !deep_sleep_select;
   wire enter_deep = (state == ST_RUN) && wait_exec && deep_sleep_select;
   wire enter_plan = enter_deep && plan_low;

   ////////////////////////////////////////////////////////////////////////
   // Unlock sequencer; window closes after a fixed time to limit stray writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         unlock_half <= 1'b0;
         unlock_cnt  <= 8'h00;
      end else if (wr_sig) begin
         unlock_half <= (wr_data[7:0] == UNLOCK_1);
         unlock_cnt  <= (unlock_half && wr_data[7:0] == UNLOCK_2)
                        ? 8'(SAFE_WINDOW_CYC) : 8'h00;
      end else if (unlocked) begin
         unlock_cnt <= unlock_cnt - 8'h01;
      end
   end

   // Clock and oscillator registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_cfg  <= RST_SYS_CLK_CFG;
         fast_pwr <= RST_FAST_PWR;
         rc_tune  <= RST_SLOW_RC_TUNE;
         xt_tune  <= RST_SLOW_XT_TUNE;
         slow_cfg <= RST_SLOW_OSC_CFG;
         pll_cfg  <= RST_PLL_CFG;
         fxt_tune <= RST_FAST_XT_TUNE;
         cal_ctrl <= RST_CAL_CTRL;
      end else begin
         if (wr_sys)  sys_cfg  <= {8'h00, wr_data[7:6], 1'b0, wr_data[4:0]};
         if (wr_fast) fast_pwr <= {3'h0, wr_data[4:2], 2'h0};
         if (wr_rc)   rc_tune  <= {3'h0, wr_data[12:0]};
         if (wr_xt)   xt_tune  <= {wr_data[7:4], 2'h0, wr_data[1:0]};
         if (wr_slow) slow_cfg <= {5'h00, wr_data[2:0]};
         if (wr_pll)  pll_cfg  <= wr_data[7:0];
         if (wr_fxt)  fxt_tune <= {1'b0, wr_data[6:4], 2'h0, wr_data[1:0]};
         if (wr_cal)  cal_ctrl <= {1'b0, wr_data[6:4], 1'b1, wr_data[2:0]};
      end
   end

   // Power plan, wake enables, peripheral gates; arm clears on plan entry
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         plan        <= RST_POWER_PLAN;
         wake_ctrl   <= RST_WAKE_CTRL;
         periph_gate <= '0;
      end else begin
         if (wr_plan)         plan <= {wr_data[15:6], 1'b0, wr_data[4:0]};
         else if (enter_plan) plan[PLAN_ARM] <= 1'b0;
         if (wr_wake) wake_ctrl   <= {2'h0, wr_data[5:3], 2'h0, wr_data[0]};
         if (wr_gate) periph_gate <= wr_data[NPERIPH-1:0];
      end
   end

   // Cause flag: a wake reset in the clearing cycle still sets it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)                 reset_cause_flag <= 1'b0;
      else if (global_wake_reset) reset_cause_flag <= 1'b1;
      else if (wr_stat && wr_data[0]) reset_cause_flag <= 1'b0;
   end

   // Read mux; unmapped addresses read zero
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (addr)
         OFS_SYS_CLK_CFG:  rd_mux = sys_cfg;
         OFS_FAST_PWR:     rd_mux = {8'h00, fast_pwr};
         OFS_SLOW_RC_TUNE: rd_mux = rc_tune;
         OFS_SLOW_XT_TUNE: rd_mux = {8'h00, xt_tune};
         OFS_SLOW_OSC_CFG: rd_mux = {8'h00, slow_cfg};
         OFS_PLL_CFG:      rd_mux = {8'h00, pll_cfg};
         OFS_FAST_XT_TUNE: rd_mux = {8'h00, fxt_tune};
         OFS_CAL_CTRL:     rd_mux = {8'h00, cal_ctrl};
         OFS_UNLOCK_SIG:   rd_mux = {15'h0000, unlocked};
         OFS_POWER_PLAN:   rd_mux = plan;
         OFS_WAKE_CTRL:    rd_mux = {8'h00, wake_ctrl};
         OFS_PERIPH_GATE:  rd_mux = DATA_W'(periph_gate);
         OFS_PMU_STATUS:   rd_mux = {12'h000, 1'b0, state};
         default:          rd_mux = '0;
      endcase
      if (addr == OFS_PMU_STATUS) rd_mux[15] = reset_cause_flag;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)     rd_data <= '0;
      else if (rd_en) rd_data <= rd_mux;
      else            rd_data <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake pins: three stages, level moves once stages two and three agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wk_s1  <= 4'h0;
         wk_s2  <= 4'h0;
         wk_s3  <= 4'h0;
         wk_lvl <= 4'h0;
      end else begin
         wk_s1  <= {wake_usb, wake_bat, wake_rtc, wake_gpio};
         wk_s2  <= wk_s1;
         wk_s3  <= wk_s2;
         // Level holds while stages two and three disagree, so a glitch cannot drop it
         wk_lvl <= (wk_s2 & wk_s3) | (wk_lvl & (wk_s2 | wk_s3));
      end
   end

   // Low-power sequencer
   wire wait_done = (wait_cnt == 8'h00);
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (enter_idle)          next_state = ST_IDLE;
            else if (deep_tgt_shut && enter_deep)  next_state = ST_SHUT;
            else if (deep_tgt_sleep && enter_deep) next_state = ST_SLEEP;
            else if (enter_deep)     next_state = ST_HALT;
         end
         ST_IDLE:     if (wake_shallow) next_state = ST_RUN;
         ST_HALT:     if (wake_shallow) next_state = ST_WAKE_CLK;
         ST_SLEEP:    if (wake_deep)    next_state = ST_WAKE_REG;
         ST_SHUT:     if (wake_deep)    next_state = ST_RUN;
         ST_WAKE_REG: if (wait_done)    next_state = ST_WAKE_CLK;
         ST_WAKE_CLK: if (wait_done)    next_state = ST_RUN;
         default:                       next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state             <= ST_RUN;
         wait_cnt          <= 8'h00;
         global_wake_reset <= 1'b0;
      end else begin
         state             <= next_state;
         global_wake_reset <= (state == ST_SHUT) && wake_deep;
         if (next_state == ST_WAKE_REG && state != ST_WAKE_REG)
            wait_cnt <= 8'(REG_SETTLE_CYC - 1);
         else if (next_state == ST_WAKE_CLK && state != ST_WAKE_CLK)
            wait_cnt <= 8'(CLK_SETTLE_CYC - 1);
         else if (!wait_done)
            wait_cnt <= wait_cnt - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power and oscillator enables
   wire in_low  = (state == ST_SLEEP) || (state == ST_SHUT);
   wire in_halt = (state == ST_HALT);
   wire halt_ok = !in_halt || fast_pwr[FAST_KEEP];
   wire plan_ok = !in_low;
   wire osc_ok  = plan_ok && (state != ST_WAKE_REG);
   assign pwr.main_reg      = !in_low || plan[PLAN_LDO];
   assign pwr.switcher_bias = plan[SW_BIAS];
   assign pwr.switcher      = plan[SW_EN];
   assign pwr.core          = (state != ST_SHUT);
   assign pwr.extend        = plan_ok || ((state == ST_SLEEP) && plan[PLAN_EXTEND]);
   assign pwr.small_retention_ram         = plan_ok || plan[PLAN_SMALL_RETENTION_RAM];
   assign pwr.main_retention_ram        = plan_ok || plan[PLAN_MAIN_RETENTION_RAM];
   assign pwr.slow_xtal     = slow_cfg[SLOW_XT_PON];
   assign pwr.slow_rc       = slow_cfg[SLOW_RC_PON];
   // Fast oscillator and PLL stay off until the main regulator has settled after sleep
   assign pwr.fast_osc      = fast_pwr[FAST_PON] && halt_ok && osc_ok;
   assign pwr.pll           = fast_pwr[PLL_PON] && halt_ok && osc_ok;

   // Core held until the sequencer is back in run
   assign core_run = (state == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // System clock: ticks of the chosen source counted by the divider; raw slow ticks bypass it
   wire clocks_run = (state == ST_RUN) || (state == ST_IDLE);
   wire slow_tick  = slow_cfg[SLOW_SEL] ? slow_xtal_tick : slow_rc_tick;
   wire src_tick   = (sh_src == SRC_SLOW) ? slow_tick
                   : (sh_src[0] ? (pll_tick && pwr.pll) : (fast_tick && pwr.fast_osc));
   wire [5:0] div_val = (sh_div == DIV_ZERO) ? DIV_MAX : {1'b0, sh_div};
   wire div_off    = (sh_src != SRC_SLOW) && (sh_div == DIV_OFF);
   wire div_wrap   = (sh_src == SRC_SLOW) || (div_cnt + 6'h01 >= div_val);
   wire tick_out   = src_tick && div_wrap && !div_off && clocks_run;

   // New settings load only at a period boundary or while the divider stops the clock, so no short pulse appears
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_src  <= RST_SYS_CLK_CFG[SRC_HI:SRC_LO];
         sh_div  <= RST_SYS_CLK_CFG[DIV_HI:DIV_LO];
         div_cnt <= 6'h00;
      end else if (div_off || (src_tick && div_wrap)) begin
         sh_src  <= sys_cfg[SRC_HI:SRC_LO];
         sh_div  <= sys_cfg[DIV_HI:DIV_LO];
         div_cnt <= 6'h00;
      end else if (src_tick) begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   // Output enables; peripherals gated per bit even while the core idles
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_clk_en    <= 1'b0;
         periph_clk_en <= '0;
         usb_clk_en    <= 1'b0;
      end else begin
         sys_clk_en    <= tick_out;
         periph_clk_en <= {NPERIPH{tick_out}} & ~periph_gate;
         usb_clk_en    <= pll_tick && pwr.pll && clocks_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_sleep_wake;
      (state == ST_SLEEP) && wake_deep;
   endsequence
   sequence s_reg_first;
      (state == ST_WAKE_REG) && pwr.main_reg && !core_run;
   endsequence

   idle_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      enter_idle |=> (state == ST_IDLE) && !core_run && pwr.main_reg)
      else $error("idle not entered");
   deep_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      enter_deep |=> (state == ST_HALT || state == ST_SLEEP || state == ST_SHUT))
      else $error("deep mode not entered");
   idle_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_IDLE) && wake_shallow |=> core_run)
      else $error("idle wake late");
   halt_order_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_HALT) && wake_shallow |=> !core_run [*2])
      else $error("core released before clocks");
   halt_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      in_halt && !fast_pwr[FAST_KEEP] |-> !pwr.fast_osc && !pwr.pll)
      else $error("fast oscillators run in halt");
   sleep_usb_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_SLEEP) && !wake_deep |=> state != ST_WAKE_REG)
      else $error("sleep woke on masked source");
   sleep_order_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_sleep_wake |=> s_reg_first ##1 !sys_clk_en)
      else $error("sleep wake order broken");
   shut_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_SHUT) && wake_deep |=> global_wake_reset ##1 reset_cause_flag)
      else $error("shutdown wake reset missing");
   locked_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
      wr_en && !unlocked && (addr == OFS_SYS_CLK_CFG) |=> $stable(sys_cfg))
      else $error("locked write took effect");
   arm_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      enter_plan && !wr_plan |=> !plan[PLAN_ARM] && in_low)
      else $error("plan arm not cleared");
   div_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      div_off |=> !sys_clk_en)
      else $error("clock runs with divider 1");
endmodule

// ### rtl/ckpm_pkg.sv
package ckpm_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   // Register offsets
   localparam logic [31:0] OFS_SYS_CLK_CFG   = 32'h4000_1008;
   localparam logic [31:0] OFS_FAST_PWR      = 32'h4000_100a;
   localparam logic [31:0] OFS_SLOW_RC_TUNE  = 32'h4000_102c;
   localparam logic [31:0] OFS_SLOW_XT_TUNE  = 32'h4000_102e;
   localparam logic [31:0] OFS_SLOW_OSC_CFG  = 32'h4000_102f;
   localparam logic [31:0] OFS_PLL_CFG       = 32'h4000_104b;
   localparam logic [31:0] OFS_FAST_XT_TUNE  = 32'h4000_104e;
   localparam logic [31:0] OFS_CAL_COUNT     = 32'h4000_1050;
   localparam logic [31:0] OFS_CAL_OVF       = 32'h4000_1052;
   localparam logic [31:0] OFS_CAL_CTRL      = 32'h4000_1053;
   localparam logic [31:0] OFS_UNLOCK_SIG    = 32'h4000_1040;
   localparam logic [31:0] OFS_POWER_PLAN    = 32'h4000_1042;
   localparam logic [31:0] OFS_WAKE_CTRL     = 32'h4000_1044;
   localparam logic [31:0] OFS_PERIPH_GATE   = 32'h4000_1045;
   localparam logic [31:0] OFS_PMU_STATUS    = 32'h4000_1046;
   // Reset values
   localparam logic [15:0] RST_SYS_CLK_CFG   = 16'h0005;
   localparam logic [7:0]  RST_FAST_PWR      = 8'h14;
   localparam logic [15:0] RST_SLOW_RC_TUNE  = 16'h1011;
   localparam logic [7:0]  RST_SLOW_XT_TUNE  = 8'hc3;
   localparam logic [7:0]  RST_SLOW_OSC_CFG  = 8'h02;
   localparam logic [7:0]  RST_PLL_CFG       = 8'h4a;
   localparam logic [7:0]  RST_FAST_XT_TUNE  = 8'h32;
   localparam logic [7:0]  RST_CAL_CTRL      = 8'h09;
   localparam logic [15:0] RST_POWER_PLAN    = 16'h11df;
   localparam logic [7:0]  RST_WAKE_CTRL     = 8'h20;
   // Field positions
   localparam int SRC_HI = 7, SRC_LO = 6, DIV_HI = 4, DIV_LO = 0;
   localparam int PLL_PON = 4, FAST_KEEP = 3, FAST_PON = 2;
   localparam int SLOW_SEL = 2, SLOW_RC_PON = 1, SLOW_XT_PON = 0;
   localparam int PLAN_ARM = 15, SW_BIAS = 10, SW_EN = 9, PLAN_LDO = 8, PLAN_SYS = 7;
   localparam int PLAN_MAIN_RETENTION_RAM = 4, PLAN_EXTEND = 3, PLAN_CORE = 2, PLAN_SMALL_RETENTION_RAM = 1;
   localparam int WK_BAT = 5, WK_GPIO = 4, WK_RTC = 3, WK_USB = 0;
   localparam int CAL_HALT = 3;
   // Field encodings
   localparam logic [1:0] SRC_SLOW  = 2'h3;
   localparam logic [4:0] DIV_OFF   = 5'h01;
   localparam logic [4:0] DIV_ZERO  = 5'h00;
   localparam logic [5:0] DIV_MAX   = 6'h20;
   localparam logic [7:0] UNLOCK_1  = 8'h57;
   localparam logic [7:0] UNLOCK_2  = 8'ha8;
   localparam int PLL_MULT = 15;
   // Timing
   localparam int CLK_MHZ           = 20;
   localparam int REG_SETTLE_NS     = 2000;
   localparam int CLK_SETTLE_NS     = 1000;
   localparam int SAFE_WINDOW_NS    = 3200;
   localparam int REG_SETTLE_CYC    = (REG_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CLK_SETTLE_CYC    = (CLK_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SAFE_WINDOW_CYC   = (SAFE_WINDOW_NS * CLK_MHZ) / 1000;

   typedef enum logic [2:0] {
      ST_RUN      = 3'b000,
      ST_IDLE     = 3'b001,
      ST_HALT     = 3'b010,
      ST_SLEEP    = 3'b011,
      ST_SHUT     = 3'b100,
      ST_WAKE_REG = 3'b101,
      ST_WAKE_CLK = 3'b110
   } ckpm_state_e;

   typedef struct packed {
      logic main_reg;
      logic switcher_bias;
      logic switcher;
      logic core;
      logic extend;
      logic small_retention_ram;
      logic main_retention_ram;
      logic slow_xtal;
      logic slow_rc;
      logic fast_osc;
      logic pll;
   } ckpm_pwr_s;
endpackage

// ### tb/ckpm_ctrl_tb.sv
`timescale 1ns/1ns
module ckpm_ctrl_tb;
   import ckpm_pkg::*;
   logic              clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, wait_exec = 0, dss = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wr_data = '0, rd_data, v;
   logic              wk_gpio = 0, wk_rtc = 0, wk_bat = 0, wk_usb = 0;
   logic              ft = 0, pt = 0, sxt = 0, srt = 0;
   logic              core_run, sys_clk_en, usb_clk_en, gwr, rcf;
   logic [7:0]        pce;
   ckpm_pwr_s         pwr;
   logic [3:0]        tcnt = 4'h0;
   int                err_total = 0, cmp_count = 0, k;
   ////////////////////////////////////////////////////////////////
   // 20 MHz clock
   always #25 clk = ~clk;
   // Source ticks: fast and PLL every other cycle, slow ones every sixteenth
   always @(posedge clk) begin
      tcnt <= tcnt + 4'h1;
      ft <= ~ft;
      pt <= tcnt[0];
      sxt <= (tcnt == 4'h0);
      srt <= (tcnt == 4'h8);
   end
   ckpm_ctrl i_ckpm_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wait_exec(wait_exec),
      .deep_sleep_select(dss), .wake_gpio(wk_gpio), .wake_rtc(wk_rtc), .wake_bat(wk_bat),
      .wake_usb(wk_usb), .fast_tick(ft), .pll_tick(pt), .slow_xtal_tick(sxt),
      .slow_rc_tick(srt), .core_run(core_run), .sys_clk_en(sys_clk_en),
      .periph_clk_en(pce), .usb_clk_en(usb_clk_en), .pwr(pwr),
      .global_wake_reset(gwr), .reset_cause_flag(rcf));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic unlock;
      wr(OFS_UNLOCK_SIG, 16'h0057);
      wr(OFS_UNLOCK_SIG, 16'h00a8);
   endtask
   task automatic park(input logic deep);
      @(posedge clk);
      dss <= deep;
      wait_exec <= 1'b1;
      @(posedge clk);
      wait_exec <= 1'b0;
      #1;
   endtask
   // Wake line held as a level; the wake decode holds no event memory, so it must stay up
   task automatic wake(output int n);
      @(posedge clk);
      wk_bat <= 1'b1;
      n = 0;
      while (core_run !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
      wk_bat <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   // Cycles between two system clock enables; first pulse only aligns
   task automatic period(output int p);
      p = 0;
      while (sys_clk_en !== 1'b1 && p < 100) begin
         @(posedge clk);
         #1 p++;
      end
      p = 0;
      do begin
         @(posedge clk);
         #1 p++;
      end while (sys_clk_en !== 1'b1 && p < 100);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(OFS_SYS_CLK_CFG, v);  check(v, RST_SYS_CLK_CFG, "sys cfg reset");
      rd(OFS_FAST_PWR, v);     check(v, 16'h0014, "fast pwr reset");
      rd(OFS_PLL_CFG, v);      check(v, 16'h004a, "pll cfg reset");
      rd(32'h4000_1000, v);    check(v, 16'h0000, "unmapped read");
      period(k);               check(16'(k), 16'd10, "fast div 5");
      k = 0;
      while (usb_clk_en !== 1'b1 && k < 4) begin
         @(posedge clk);
         #1 k++;
      end
      check(16'(usb_clk_en), 16'h1, "usb clock from pll");
   endtask
   task automatic t_lock;
      wr(OFS_SYS_CLK_CFG, 16'h00c2);
      rd(OFS_SYS_CLK_CFG, v);  check(v, 16'h0005, "locked write");
      unlock();
      wr(OFS_SYS_CLK_CFG, 16'h00c2);
      rd(OFS_SYS_CLK_CFG, v);  check(v, 16'h00c2, "unlocked write");
      period(k);
      period(k);               check(16'(k), 16'd16, "raw slow rc");
      unlock();
      wr(OFS_SYS_CLK_CFG, 16'h0001);
      // Old slow period must end before the stop takes hold
      repeat (20) @(posedge clk);
      k = 0;
      repeat (32) begin
         @(posedge clk);
         #1 k += sys_clk_en;
      end
      check(16'(k), 16'h0, "divider 1 stops clock");
      unlock();
      wr(OFS_SYS_CLK_CFG, 16'h0005);
      unlock();
      wr(OFS_POWER_PLAN, 16'h15df);
      check(16'(pwr.switcher_bias), 16'h1, "bias at once");
      wr(OFS_POWER_PLAN, 16'h17df);
      check(16'({pwr.switcher_bias, pwr.switcher}), 16'h3, "switcher on");
      unlock();
      wr(OFS_POWER_PLAN, 16'h11df);
      check(16'({pwr.switcher_bias, pwr.switcher}), 16'h0, "direct power");
   endtask
   task automatic t_idle;
      unlock();
      wr(OFS_PERIPH_GATE, 16'h0001);
      park(1'b0);              check(16'(core_run), 16'h0, "idle entry");
      check(16'(pwr.fast_osc), 16'h1, "idle clocks on");
      period(k);               check(16'(k), 16'd10, "idle sys clock runs");
      check(16'(pce), 16'h00fe, "gated peripheral clock");
      wake(k);                 check(16'(k <= 8), 16'h1, "idle wake fast");
   endtask
   task automatic t_halt;
      park(1'b1);              check(16'(core_run), 16'h0, "halt entry");
      check(16'({pwr.fast_osc, pwr.pll}), 16'h0, "halt fast osc off");
      @(posedge clk);
      #1 check(16'({usb_clk_en, sys_clk_en}), 16'h0, "halt clocks stopped");
      wake(k);                 check(16'(k >= 20 && k <= 30), 16'h1, "halt wake");
   endtask
   // Armed plan with core kept selects sleep; USB enabled but must not wake it
   task automatic t_sleep;
      unlock();
      wr(OFS_WAKE_CTRL, 16'h0021);
      wr(OFS_POWER_PLAN, 16'h9006);
      park(1'b1);
      check(16'({pwr.main_reg, pwr.core}), 16'h1, "sleep regulators");
      check(16'({pwr.extend, pwr.small_retention_ram, pwr.main_retention_ram}), 16'h2, "sleep retention");
      @(posedge clk);
      wk_usb <= 1'b1;
      repeat (10) @(posedge clk);
      wk_usb <= 1'b0;
      #1 check(16'(core_run), 16'h0, "usb wake refused");
      wake(k);
      k -= REG_SETTLE_CYC + CLK_SETTLE_CYC;
      check(16'(k >= 0 && k <= 8), 16'h1, "sleep wake sequence");
   endtask
   // Armed plan with core off selects shutdown
   task automatic t_shut;
      unlock();
      wr(OFS_POWER_PLAN, 16'h9000);
      park(1'b1);              check(16'(pwr.core), 16'h0, "shut core off");
      check(16'(pwr.extend), 16'h0, "shut usb rf off");
      @(posedge clk);
      wk_bat <= 1'b1;
      k = 0;
      while (gwr !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1 k++;
      end
      check(16'(gwr), 16'h1, "wake reset pulse");
      @(posedge clk);
      wk_bat <= 1'b0;
      @(posedge clk);
      #1 check(16'(rcf), 16'h1, "reset cause set");
      rd(OFS_POWER_PLAN, v);   check(16'(v[PLAN_ARM]), 16'h0, "arm cleared");
      rd(OFS_PMU_STATUS, v);   check(v, 16'h8000, "status shows cause");
      wr(OFS_PMU_STATUS, 16'h0001);
      check(16'(rcf), 16'h0, "cause cleared");
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(20000 * 50);
      err_total++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_lock();
      t_idle();
      t_halt();
      t_sleep();
      t_shut();
      give_verdict();
   end
endmodule
